// ==== inc/ppc_pkg.sv ====
package ppc_pkg;
  // ----------------------------------------------------------------
  // object indices
  // ----------------------------------------------------------------
  localparam logic [15:0] PPC_IDX_CTRL = 16'h6040;
  localparam logic [15:0] PPC_IDX_MODE = 16'h6060;
  localparam logic [15:0] PPC_IDX_POS_UNIT = 16'h60A8;
  localparam logic [15:0] PPC_IDX_SPD_UNIT = 16'h60A9;
  localparam logic [15:0] PPC_IDX_SPD_FAC = 16'h6096;
  localparam logic [15:0] PPC_IDX_ACC_FAC = 16'h6097;
  localparam logic [15:0] PPC_IDX_JRK_FAC = 16'h60A2;
  localparam logic [15:0] PPC_IDX_VL_DIM = 16'h604C;
  localparam logic [15:0] PPC_IDX_SW_LIM = 16'h607D;
  localparam logic [15:0] PPC_IDX_TARGET = 16'h607A;
  localparam logic [15:0] PPC_IDX_POS_OPT = 16'h60F2;
  localparam logic [15:0] PPC_IDX_HALT_OPT = 16'h605D;
  localparam logic [7:0] PPC_SUB_NUM = 8'h01;
  localparam logic [7:0] PPC_SUB_DEN = 8'h02;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int PPC_TIME_LSB = 8;
  localparam int PPC_UNIT_LSB = 16;
  localparam int PPC_EXP_LSB = 24;
  localparam logic [31:0] PPC_POS_UNIT_RST = 32'hFF410000;
  localparam logic [31:0] PPC_SPD_UNIT_RST = 32'h00B44700;
  localparam logic [31:0] PPC_VL_UNIT = 32'h00B44700;
  localparam logic [31:0] PPC_FAC_RST = 32'h00000001;
  localparam logic [31:0] PPC_LIM_MIN_RST = 32'h80000000;
  localparam logic [31:0] PPC_LIM_MAX_RST = 32'h7FFFFFFF;
  // ----------------------------------------------------------------
  // controlword bits, modes, codes
  // ----------------------------------------------------------------
  localparam int PPC_CW_NEW = 4;
  localparam int PPC_CW_IMM = 5;
  localparam int PPC_CW_REL = 6;
  localparam int PPC_CW_HALT = 8;
  localparam int PPC_CW_CHG = 9;
  localparam logic [7:0] PPC_MODE_PP = 8'h01;
  localparam logic [7:0] PPC_MODE_VL = 8'h02;
  localparam logic [7:0] PPC_EXP_MIN = 8'hFA;
  localparam logic [7:0] PPC_EXP_MAX = 8'h06;
  localparam logic [7:0] PPC_U_M = 8'h01, PPC_U_IN = 8'hC1, PPC_U_FT = 8'hC2;
  localparam logic [7:0] PPC_U_GRD = 8'h40, PPC_U_RAD = 8'h10, PPC_U_DEG = 8'h41;
  localparam logic [7:0] PPC_U_AMIN = 8'h42, PPC_U_ASEC = 8'h43, PPC_U_REV = 8'hB4;
  localparam logic [7:0] PPC_U_INC = 8'hB5, PPC_U_STEP = 8'hAC, PPC_U_POLE = 8'hC0;
  localparam logic [7:0] PPC_U_NONE = 8'h00;
  localparam logic [7:0] PPC_T_S = 8'h03, PPC_T_MIN = 8'h47, PPC_T_H = 8'h48;
  localparam logic [7:0] PPC_T_D = 8'h49, PPC_T_A = 8'h4A;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PPC_CLK_HZ = 25_000_000;
  localparam int PPC_APP_US = 1000;
  localparam int PPC_VEL_US = 250;
  localparam int PPC_CUR_US = 50;
  localparam int PPC_APP_CYC = PPC_CLK_HZ / 1_000_000 * PPC_APP_US;
  localparam int PPC_VEL_CYC = PPC_CLK_HZ / 1_000_000 * PPC_VEL_US;
  localparam int PPC_CUR_CYC = PPC_CLK_HZ / 1_000_000 * PPC_CUR_US;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {PPC_IDLE, PPC_MOVE} ppc_trv_e;
  typedef struct packed {
    logic wr; logic rd; logic [15:0] idx; logic [7:0] sub; logic [31:0] wdata;
  } ppc_od_req_s;
  typedef struct packed {
    logic ack; logic err; logic [31:0] rdata;
  } ppc_od_rsp_s;
  typedef struct packed {
    logic [7:0] pos_code; logic [7:0] pos_exp;
    logic [7:0] time_code; logic [7:0] spd_code; logic [7:0] spd_exp;
    logic [31:0] spd_num; logic [31:0] spd_den;
    logic [31:0] acc_num; logic [31:0] acc_den;
    logic [31:0] jrk_num; logic [31:0] jrk_den;
  } ppc_scale_s;
  typedef struct packed {
    logic valid; logic [31:0] target; logic imm; logic pass_thru;
    logic halt; logic [15:0] halt_opt;
  } ppc_sp_s;
endpackage : ppc_pkg

// ==== verilog/ppc_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// - position unit: code 23:16, exponent 31:24
// - speed unit: time, position, exponent fields
// - speed scaled by numerator over denominator
// - acceleration factor numerator over denominator
// - jerk factor numerator over denominator
// - velocity mode fixed rpm, own factor
// - targets clamped to software limits
// - outside range: only moves toward range
// - inputs sampled once per application cycle
// - current, velocity, application cycle ticks
// - relative or absolute targets, limits respected
// - travel starts on bit 4 rise
// - mode entry with bit 4 high starts
// - bit 5 immediate, else queue after finish
// - bit 6 relative, option bits pick reference
// - bit 8 halts with halt option
// - bit 9 passes target without braking
// - bits 9,5 low: finish then next
// - exponents limited to minus six..six
// - position unit codes validated
// - time unit codes validated
// - unit changes applied only outside operation
module ppc_core #(
  parameter int APP_CYC = ppc_pkg::PPC_APP_CYC,
  parameter int VEL_CYC = ppc_pkg::PPC_VEL_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire ppc_pkg::ppc_od_req_s od_req,
  input wire logic op_enabled,
  input wire logic [31:0] pos_actual,
  input wire logic move_done,
  output ppc_pkg::ppc_od_rsp_s od_rsp,
  output ppc_pkg::ppc_scale_s scale,
  output ppc_pkg::ppc_sp_s sp,
  output logic cur_tick,
  output logic vel_tick,
  output logic app_tick,
  output logic busy,
  output logic reject
);
  import ppc_pkg::*;

  typedef struct packed {
    logic [15:0] ctrl; logic [7:0] mode;
    logic [31:0] pos_unit; logic [31:0] spd_unit;
    logic [31:0] spd_num; logic [31:0] spd_den;
    logic [31:0] acc_num; logic [31:0] acc_den;
    logic [31:0] jrk_num; logic [31:0] jrk_den;
    logic [31:0] vl_num; logic [31:0] vl_den;
    logic [31:0] lim_min; logic [31:0] lim_max;
    logic [31:0] target; logic [31:0] last_tgt;
    logic [15:0] pos_opt; logic [15:0] halt_opt;
    logic [15:0] cw_smp; logic [7:0] mode_smp;
    logic [31:0] app_cnt; logic [31:0] vel_cnt; logic [31:0] cur_cnt;
    logic app_tick; logic vel_tick; logic cur_tick;
    ppc_trv_e trv; logic busy; logic pend; logic pend_pass; logic [31:0] pend_tgt;
    ppc_sp_s sp; ppc_od_rsp_s rsp; ppc_scale_s scale; logic reject;
  } ppc_state_s;

  ppc_state_s q, d;
  logic ok;
  logic trig;
  logic bad;
  logic [31:0] rdv;
  logic [31:0] w;
  logic signed [31:0] base, raw, cl, pa, lmin, lmax;

  // ----------------------------------------------------------------
  // code checks
  // ----------------------------------------------------------------
  function automatic logic exp_ok(input logic [7:0] e);
    exp_ok = ($signed(e) >= $signed(PPC_EXP_MIN)) && ($signed(e) <= $signed(PPC_EXP_MAX));
  endfunction : exp_ok

  function automatic logic pos_ok(input logic [7:0] u);
    case (u)
      PPC_U_M, PPC_U_IN, PPC_U_FT, PPC_U_GRD, PPC_U_RAD, PPC_U_DEG,
      PPC_U_AMIN, PPC_U_ASEC, PPC_U_REV, PPC_U_INC, PPC_U_STEP,
      PPC_U_POLE, PPC_U_NONE: pos_ok = 1'b1;
      default: pos_ok = 1'b0;
    endcase
  endfunction : pos_ok

  function automatic logic time_ok(input logic [7:0] t);
    case (t)
      PPC_T_S, PPC_T_MIN, PPC_T_H, PPC_T_D, PPC_T_A: time_ok = 1'b1;
      default: time_ok = 1'b0;
    endcase
  endfunction : time_ok

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.rsp = '0;
    d.sp.valid = 1'b0;
    d.reject = 1'b0;
    ok = 1'b1;
    rdv = 32'h00000000;
    w = od_req.wdata;
    trig = 1'b0;
    // loop rate ticks
    d.cur_tick = (q.cur_cnt == 32'(PPC_CUR_CYC - 1));
    d.cur_cnt = d.cur_tick ? 32'h00000000 : q.cur_cnt + 32'h00000001;
    d.vel_tick = (q.vel_cnt == 32'(VEL_CYC - 1));
    d.vel_cnt = d.vel_tick ? 32'h00000000 : q.vel_cnt + 32'h00000001;
    d.app_tick = (q.app_cnt == 32'(APP_CYC - 1));
    d.app_cnt = d.app_tick ? 32'h00000000 : q.app_cnt + 32'h00000001;
    // object access
    case (od_req.idx)
      PPC_IDX_CTRL: begin
        rdv = {16'h0000, q.ctrl};
        if (od_req.wr) d.ctrl = w[15:0];
      end
      PPC_IDX_MODE: begin
        rdv = {24'h000000, q.mode};
        if (od_req.wr) d.mode = w[7:0];
      end
      PPC_IDX_POS_UNIT: begin
        rdv = q.pos_unit;
        ok = !od_req.wr || (exp_ok(w[PPC_EXP_LSB +: 8]) && pos_ok(w[PPC_UNIT_LSB +: 8]));
        if (od_req.wr && ok) d.pos_unit = {w[31:16], 16'h0000};
      end
      PPC_IDX_SPD_UNIT: begin
        rdv = q.spd_unit;
        ok = !od_req.wr || (exp_ok(w[PPC_EXP_LSB +: 8]) && pos_ok(w[PPC_UNIT_LSB +: 8])
             && time_ok(w[PPC_TIME_LSB +: 8]));
        if (od_req.wr && ok) d.spd_unit = {w[31:8], 8'h00};
      end
      PPC_IDX_SPD_FAC: begin
        rdv = (od_req.sub == PPC_SUB_NUM) ? q.spd_num : q.spd_den;
        ok = (od_req.sub == PPC_SUB_NUM) || (od_req.sub == PPC_SUB_DEN && (!od_req.wr || w != 0));
        if (od_req.wr && ok && od_req.sub == PPC_SUB_NUM) d.spd_num = w;
        if (od_req.wr && ok && od_req.sub == PPC_SUB_DEN) d.spd_den = w;
      end
      PPC_IDX_ACC_FAC: begin
        rdv = (od_req.sub == PPC_SUB_NUM) ? q.acc_num : q.acc_den;
        ok = (od_req.sub == PPC_SUB_NUM) || (od_req.sub == PPC_SUB_DEN && (!od_req.wr || w != 0));
        if (od_req.wr && ok && od_req.sub == PPC_SUB_NUM) d.acc_num = w;
        if (od_req.wr && ok && od_req.sub == PPC_SUB_DEN) d.acc_den = w;
      end
      PPC_IDX_JRK_FAC: begin
        rdv = (od_req.sub == PPC_SUB_NUM) ? q.jrk_num : q.jrk_den;
        ok = (od_req.sub == PPC_SUB_NUM) || (od_req.sub == PPC_SUB_DEN && (!od_req.wr || w != 0));
        if (od_req.wr && ok && od_req.sub == PPC_SUB_NUM) d.jrk_num = w;
        if (od_req.wr && ok && od_req.sub == PPC_SUB_DEN) d.jrk_den = w;
      end
      PPC_IDX_VL_DIM: begin
        rdv = (od_req.sub == PPC_SUB_NUM) ? q.vl_num : q.vl_den;
        ok = (od_req.sub == PPC_SUB_NUM) || (od_req.sub == PPC_SUB_DEN && (!od_req.wr || w != 0));
        if (od_req.wr && ok && od_req.sub == PPC_SUB_NUM) d.vl_num = w;
        if (od_req.wr && ok && od_req.sub == PPC_SUB_DEN) d.vl_den = w;
      end
      PPC_IDX_SW_LIM: begin
        rdv = (od_req.sub == PPC_SUB_NUM) ? q.lim_min : q.lim_max;
        ok = (od_req.sub == PPC_SUB_NUM) || (od_req.sub == PPC_SUB_DEN);
        if (od_req.wr && ok && od_req.sub == PPC_SUB_NUM) d.lim_min = w;
        if (od_req.wr && ok && od_req.sub == PPC_SUB_DEN) d.lim_max = w;
      end
      PPC_IDX_TARGET: begin
        rdv = q.target;
        if (od_req.wr) d.target = w;
      end
      PPC_IDX_POS_OPT: begin
        rdv = {16'h0000, q.pos_opt};
        if (od_req.wr) d.pos_opt = w[15:0];
      end
      PPC_IDX_HALT_OPT: begin
        rdv = {16'h0000, q.halt_opt};
        if (od_req.wr) d.halt_opt = w[15:0];
      end
      default: ok = 1'b0;
    endcase
    if (od_req.wr || od_req.rd) begin
      d.rsp.ack = 1'b1;
      d.rsp.err = !ok;
      d.rsp.rdata = ok ? rdv : 32'h00000000;
    end
    // applied scaling, frozen while operation is enabled
    if (!op_enabled) begin
      d.scale.pos_code = q.pos_unit[PPC_UNIT_LSB +: 8];
      d.scale.pos_exp = q.pos_unit[PPC_EXP_LSB +: 8];
      d.scale.acc_num = q.acc_num;
      d.scale.acc_den = q.acc_den;
      d.scale.jrk_num = q.jrk_num;
      d.scale.jrk_den = q.jrk_den;
      if (q.mode == PPC_MODE_VL) begin
        d.scale.time_code = PPC_VL_UNIT[PPC_TIME_LSB +: 8];
        d.scale.spd_code = PPC_VL_UNIT[PPC_UNIT_LSB +: 8];
        d.scale.spd_exp = PPC_VL_UNIT[PPC_EXP_LSB +: 8];
        d.scale.spd_num = q.vl_num;
        d.scale.spd_den = q.vl_den;
      end else begin
        d.scale.time_code = q.spd_unit[PPC_TIME_LSB +: 8];
        d.scale.spd_code = q.spd_unit[PPC_UNIT_LSB +: 8];
        d.scale.spd_exp = q.spd_unit[PPC_EXP_LSB +: 8];
        d.scale.spd_num = q.spd_num;
        d.scale.spd_den = q.spd_den;
      end
    end
    // target resolution: reference, clamp, direction check
    pa = $signed(pos_actual);
    lmin = $signed(q.lim_min);
    lmax = $signed(q.lim_max);
    base = (q.pos_opt[1:0] == 2'b00) ? $signed(q.last_tgt) : pa;
    raw = q.ctrl[PPC_CW_REL] ? base + $signed(q.target) : $signed(q.target);
    cl = (raw < lmin) ? lmin : ((raw > lmax) ? lmax : raw);
    bad = ((pa > lmax) && (raw >= pa)) || ((pa < lmin) && (raw <= pa));
    // application cycle sampling
    if (q.app_tick) begin
      d.cw_smp = q.ctrl;
      d.mode_smp = q.mode;
      trig = (q.mode == PPC_MODE_PP) && q.ctrl[PPC_CW_NEW]
             && (!q.cw_smp[PPC_CW_NEW] || q.mode_smp != PPC_MODE_PP);
      d.sp.halt = q.ctrl[PPC_CW_HALT] && (q.mode == PPC_MODE_PP);
      d.sp.halt_opt = q.halt_opt;
    end
    // travel sequencing
    case (q.trv)
      PPC_MOVE: begin
        if (move_done) begin
          if (q.pend) begin
            d.sp.valid = 1'b1;
            d.sp.target = q.pend_tgt;
            d.sp.imm = 1'b0;
            d.sp.pass_thru = q.pend_pass;
            d.last_tgt = q.pend_tgt;
            d.pend = 1'b0;
          end else begin
            d.trv = PPC_IDLE;
          end
        end
      end
      PPC_IDLE: d.trv = PPC_IDLE;
      default: d.trv = PPC_IDLE;
    endcase
    if (trig) begin
      if (bad) begin
        d.reject = 1'b1;
      end else if (q.ctrl[PPC_CW_IMM] || (d.trv == PPC_IDLE && !d.sp.valid)) begin
        d.sp.valid = 1'b1;
        d.sp.target = cl;
        d.sp.imm = q.ctrl[PPC_CW_IMM];
        d.sp.pass_thru = 1'b0;
        d.last_tgt = cl;
        d.pend = 1'b0;
        d.trv = PPC_MOVE;
      end else if (!d.pend) begin
        d.pend = 1'b1;
        d.pend_tgt = cl;
        d.pend_pass = q.ctrl[PPC_CW_CHG];
        d.sp.pass_thru = q.ctrl[PPC_CW_CHG] && !d.sp.valid;
      end else begin
        d.reject = 1'b1;
      end
    end
    d.busy = (d.trv == PPC_MOVE);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
      q.pos_unit <= PPC_POS_UNIT_RST;
      q.spd_unit <= PPC_SPD_UNIT_RST;
      q.spd_num <= PPC_FAC_RST;
      q.spd_den <= PPC_FAC_RST;
      q.acc_num <= PPC_FAC_RST;
      q.acc_den <= PPC_FAC_RST;
      q.jrk_num <= PPC_FAC_RST;
      q.jrk_den <= PPC_FAC_RST;
      q.vl_num <= PPC_FAC_RST;
      q.vl_den <= PPC_FAC_RST;
      q.lim_min <= PPC_LIM_MIN_RST;
      q.lim_max <= PPC_LIM_MAX_RST;
      q.trv <= PPC_IDLE;
      q.scale <= {PPC_POS_UNIT_RST[23:16], PPC_POS_UNIT_RST[31:24], PPC_SPD_UNIT_RST[15:8],
                  PPC_SPD_UNIT_RST[23:16], PPC_SPD_UNIT_RST[31:24], {6{PPC_FAC_RST}}};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign od_rsp = q.rsp;
  assign scale = q.scale;
  assign sp = q.sp;
  assign cur_tick = q.cur_tick;
  assign vel_tick = q.vel_tick;
  assign app_tick = q.app_tick;
  assign busy = q.busy;
  assign reject = q.reject;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_pos_unit_wr;
    od_req.wr && od_req.idx == PPC_IDX_POS_UNIT && !d.rsp.err
      |=> q.pos_unit == {$past(od_req.wdata[31:16]), 16'h0000};
  endproperty
  a_pos_unit_wr: assert property (p_pos_unit_wr) else $error("position unit write wrong");

  property p_spd_unit_wr;
    od_req.wr && od_req.idx == PPC_IDX_SPD_UNIT && !d.rsp.err
      |=> q.spd_unit[7:0] == 8'h00 && q.spd_unit[31:8] == $past(od_req.wdata[31:8]);
  endproperty
  a_spd_unit_wr: assert property (p_spd_unit_wr) else $error("speed unit write wrong");

  property p_exp_range;
    $signed(q.pos_unit[31:24]) >= -8'sd6 && $signed(q.pos_unit[31:24]) <= 8'sd6;
  endproperty
  a_exp_range: assert property (p_exp_range) else $error("exponent out of range");

  property p_clamp;
    q.sp.valid |-> $signed(q.sp.target) >= $signed(q.lim_min)
                   && $signed(q.sp.target) <= $signed(q.lim_max);
  endproperty
  a_clamp: assert property (p_clamp) else $error("target outside limits");

  property p_cur_gap;
    q.cur_tick |=> !q.cur_tick [*8];
  endproperty
  a_cur_gap: assert property (p_cur_gap) else $error("current tick too soon");

  property p_sample;
    q.sp.valid |-> $past(q.app_tick) || $past(move_done);
  endproperty
  a_sample: assert property (p_sample) else $error("setpoint off application cycle");

  property p_freeze;
    op_enabled && $past(op_enabled) |-> $stable(q.scale);
  endproperty
  a_freeze: assert property (p_freeze) else $error("units changed while enabled");

  property p_vl_rpm;
    $past(!op_enabled && q.mode == PPC_MODE_VL) |-> q.scale.spd_code == PPC_VL_UNIT[23:16]
      && q.scale.time_code == PPC_VL_UNIT[15:8];
  endproperty
  a_vl_rpm: assert property (p_vl_rpm) else $error("velocity mode unit not rpm");

  property p_queue;
    q.sp.valid && $past(q.busy) && !$past(move_done) |-> q.sp.imm;
  endproperty
  a_queue: assert property (p_queue) else $error("setpoint replaced without bit 5");

  c_imm: cover property (q.sp.valid && q.sp.imm && $past(q.busy));
  c_pend: cover property (q.pend ##[1:1000] (q.sp.valid && !q.sp.imm));
  c_reject: cover property (q.reject);
  c_halt: cover property ($rose(q.sp.halt));

endmodule : ppc_core

// ==== bench/ppc_host.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// fieldbus host model: object dictionary accesses
// ----------------------------------------------------------------
module ppc_host (
  input wire logic clk,
  output ppc_pkg::ppc_od_req_s od_req
);
  import ppc_pkg::*;
  logic [33:0] exp_q[$]; // expected {is_read, err, rdata}
  // one access: strobe one cycle, then release lines to inverted values
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, input logic [33:0] e);
    @(negedge clk);
    od_req <= '{wr: w, rd: !w, idx: i, sub: s, wdata: d};
    exp_q.push_back(e);
    @(negedge clk);
    od_req <= '{wr: 1'b0, rd: 1'b0, idx: ~i, sub: ~s, wdata: ~d};
  endtask : acc
  // select profile position operation
  task automatic set_pp();
    acc(1'b1, PPC_IDX_MODE, 8'h00, {24'h0, PPC_MODE_PP}, 34'h0);
  endtask : set_pp
  initial od_req = '0;
endmodule : ppc_host

// ==== bench/profile_position_command_unit_bench.sv ====
`timescale 1ns/1ps
module profile_position_command_unit_bench;
  import ppc_pkg::*;
  localparam int APP = 40;
  localparam int VEL = 20;
  logic clk, nrst, op_enabled, move_done, cur_tick, vel_tick, app_tick, busy, reject;
  logic [31:0] pos_actual, x32;
  ppc_od_req_s od_req;
  ppc_od_rsp_s od_rsp;
  ppc_scale_s scale;
  ppc_sp_s sp;
  int failures, tests_run, cyc;
  int n[3];
  int per[3] = '{APP, VEL, 1250};
  logic [34:0] sp_q[$]; // expected {reject, imm, pass_thru, target}
  logic [33:0] e;
  logic [34:0] s;
  logic [7:0] x;
  logic [7:0] pc[6] = '{8'h01, 8'h41, 8'hB4, 8'hB5, 8'hAC, 8'h00};
  logic [7:0] tc[5] = '{8'h03, 8'h47, 8'h48, 8'h49, 8'h4A};
  logic [15:0] fi[3] = '{PPC_IDX_SPD_FAC, PPC_IDX_ACC_FAC, PPC_IDX_JRK_FAC};
  logic [31:0] nn[3], dd[3];
  logic [2:0] tk;
  ppc_core #(.APP_CYC(APP), .VEL_CYC(VEL)) i_dut (.clk(clk), .nrst(nrst), .od_req(od_req),
    .op_enabled(op_enabled), .pos_actual(pos_actual), .move_done(move_done), .od_rsp(od_rsp),
    .scale(scale), .sp(sp), .cur_tick(cur_tick), .vel_tick(vel_tick), .app_tick(app_tick),
    .busy(busy), .reject(reject));
  ppc_host i_host (.clk(clk), .od_req(od_req));
  // ----------------------------------------------------------------
  // compare, report, access helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic check_rsp(input logic [32:0] got, input logic [32:0] exp);
    check({31'h0, got}, {31'h0, exp});
  endtask : check_rsp
  task automatic check_sp(input logic [34:0] got, input logic [34:0] exp);
    check({29'h0, got}, {29'h0, exp});
  endtask : check_sp
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [15:0] i, input logic [7:0] b, input logic [31:0] d,
    input logic er);
    i_host.acc(1'b1, i, b, d, {1'b0, er, 32'h0});
  endtask : wr
  task automatic rd(input logic [15:0] i, input logic [7:0] b, input logic [31:0] d);
    i_host.acc(1'b0, i, b, 32'h0, {1'b1, 1'b0, d});
  endtask : rd
  // new target then a bit 4 rise spanning app ticks
  task automatic mv(input logic [31:0] t, input logic [15:0] cw);
    wr(PPC_IDX_TARGET, 8'h00, t, 1'b0);
    wr(PPC_IDX_CTRL, 8'h00, {16'h0, cw & 16'hFFEF}, 1'b0);
    repeat (2 * APP) @(negedge clk);
    wr(PPC_IDX_CTRL, 8'h00, {16'h0, cw | 16'h0010}, 1'b0);
    repeat (2 * APP) @(negedge clk);
  endtask : mv
  task automatic done();
    @(negedge clk);
    move_done <= 1'b1;
    @(negedge clk);
    move_done <= 1'b0;
    repeat (4) @(negedge clk);
  endtask : done
  // ----------------------------------------------------------------
  // clock, timeout, output watcher
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // output watcher: tick periods, object answers, setpoints
  always @(negedge clk) begin
    tk = {cur_tick, vel_tick, app_tick};
    for (int i = 0; i < 3; i++) begin
      if (!nrst) n[i] = 0;
      else if (tk[i] === 1'b1) begin
        if (n[i] > 0) check(n[i], per[i]);
        n[i] = 1;
      end else if (n[i] > 0) n[i]++;
    end
    if (nrst && od_rsp.ack === 1'b1) begin
      e = i_host.exp_q.pop_front();
      check_rsp({od_rsp.err, e[33] ? od_rsp.rdata : 32'h0}, e[32:0]);
    end
    if (nrst && (sp.valid === 1'b1 || reject === 1'b1)) begin
      s = sp_q.pop_front();
      check_sp(reject ? {reject, 34'h0} : {reject, sp.imm, sp.pass_thru, sp.target}, s);
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    op_enabled = 1'b0;
    move_done = 1'b0;
    pos_actual = 32'h0;
    void'($urandom(32'hCE72));
    repeat (6) @(negedge clk);
    nrst <= 1'b1;
    rd(PPC_IDX_POS_UNIT, 8'h00, 32'hFF410000);
    rd(PPC_IDX_SPD_UNIT, 8'h00, 32'h00B44700);
    check({scale.pos_exp, scale.pos_code, scale.time_code, scale.spd_code}, 32'hFF4147B4);
    $display("reset values done");
    foreach (pc[k]) begin
      x = 8'(250 + $urandom % 13);
      x32 = {x, pc[k], 16'h0};
      wr(PPC_IDX_POS_UNIT, 8'h00, x32, 1'b0);
      rd(PPC_IDX_POS_UNIT, 8'h00, x32);
      check({scale.pos_exp, scale.pos_code}, x32[31:16]);
    end
    foreach (tc[k]) begin
      x32 = {8'(250 + $urandom % 13), pc[k], tc[k], 8'h00};
      wr(PPC_IDX_SPD_UNIT, 8'h00, x32, 1'b0);
      @(negedge clk);
      check({scale.spd_exp, scale.spd_code, scale.time_code}, x32[31:8]);
    end
    wr(PPC_IDX_POS_UNIT, 8'h00, 32'h07410000, 1'b1);
    wr(PPC_IDX_POS_UNIT, 8'h00, 32'h00020000, 1'b1);
    wr(PPC_IDX_SPD_UNIT, 8'h00, 32'h00B40500, 1'b1);
    wr(16'h1234, 8'h00, 32'h0, 1'b1);
    foreach (fi[k]) begin
      nn[k] = $urandom;
      dd[k] = $urandom | 32'h1;
      wr(fi[k], PPC_SUB_NUM, nn[k], 1'b0);
      wr(fi[k], PPC_SUB_DEN, dd[k], 1'b0);
      wr(fi[k], PPC_SUB_DEN, 32'h0, 1'b1);
      wr(fi[k], 8'h03, 32'h5, 1'b1);
    end
    check({scale.spd_num, scale.spd_den}, {nn[0], dd[0]});
    check({scale.acc_num, scale.acc_den}, {nn[1], dd[1]});
    check({scale.jrk_num, scale.jrk_den}, {nn[2], dd[2]});
    op_enabled <= 1'b1;
    wr(PPC_IDX_POS_UNIT, 8'h00, 32'hFAB40000, 1'b0);
    repeat (3) @(negedge clk);
    check(scale.pos_code, pc[5]);
    op_enabled <= 1'b0;
    repeat (3) @(negedge clk);
    check({scale.pos_exp, scale.pos_code}, 16'hFAB4);
    $display("units and factors done");
    wr(PPC_IDX_SW_LIM, PPC_SUB_NUM, 32'hFFFFFC18, 1'b0);
    wr(PPC_IDX_SW_LIM, PPC_SUB_DEN, 32'h000003E8, 1'b0);
    wr(PPC_IDX_SW_LIM, 8'h03, 32'h0, 1'b1);
    wr(PPC_IDX_POS_OPT, 8'h00, 32'h0, 1'b0);
    i_host.set_pp();
    sp_q.push_back({3'b000, 32'h000001F4});
    mv(32'h000001F4, 16'h0000);
    check(busy, 1'b1);
    done();
    check(busy, 1'b0);
    sp_q.push_back({3'b000, 32'h000002BC});
    mv(32'h000000C8, 16'h0040);
    done();
    sp_q.push_back({3'b000, 32'h000003E8});
    mv(32'h00001388, 16'h0000);
    done();
    sp_q.push_back({3'b000, 32'hFFFFFC18});
    mv(32'hFFFFEC78, 16'h0000);
    mv(32'h0000012C, 16'h0200);
    sp_q.push_back({3'b100, 32'h0});
    mv(32'h00000190, 16'h0200);
    sp_q.push_back({3'b001, 32'h0000012C});
    done();
    sp_q.push_back({3'b010, 32'hFFFFFED4});
    mv(32'hFFFFFED4, 16'h0020);
    done();
    done();
    $display("travel commands done");
    pos_actual <= 32'h000007D0;
    sp_q.push_back({3'b100, 32'h0});
    mv(32'h00000BB8, 16'h0000);
    sp_q.push_back({3'b000, 32'h0});
    mv(32'h0, 16'h0000);
    done();
    pos_actual <= 32'h00000064;
    wr(PPC_IDX_HALT_OPT, 8'h00, 32'h00000002, 1'b0);
    wr(PPC_IDX_CTRL, 8'h00, 32'h00000100, 1'b0);
    repeat (2 * APP) @(negedge clk);
    check({sp.halt, sp.halt_opt}, {1'b1, 16'h0002});
    wr(PPC_IDX_CTRL, 8'h00, 32'h0, 1'b0);
    repeat (2 * APP) @(negedge clk);
    check(sp.halt, 1'b0);
    wr(PPC_IDX_POS_OPT, 8'h00, 32'h00000001, 1'b0);
    sp_q.push_back({3'b000, 32'h00000096});
    mv(32'h00000032, 16'h0040);
    done();
    wr(PPC_IDX_VL_DIM, PPC_SUB_NUM, 32'h00000003, 1'b0);
    wr(PPC_IDX_MODE, 8'h00, {24'h0, PPC_MODE_VL}, 1'b0);
    wr(PPC_IDX_TARGET, 8'h00, 32'h00000032, 1'b0);
    wr(PPC_IDX_CTRL, 8'h00, 32'h00000010, 1'b0);
    repeat (2 * APP) @(negedge clk);
    check({scale.spd_exp, scale.spd_code, scale.time_code, scale.spd_num},
      {PPC_VL_UNIT[31:8], 32'h00000003});
    sp_q.push_back({3'b000, 32'h00000032});
    i_host.set_pp();
    repeat (2 * APP) @(negedge clk);
    done();
    $display("halt and mode entry done");
    repeat (1300) @(negedge clk);
    check({sp_q.size(), i_host.exp_q.size()}, 64'h0);
    give_verdict();
  end
endmodule : profile_position_command_unit_bench
